// >>> hw/sbrg_rate_gen.sv
// serial baud rate generator with its control registers on an apb slave
//
// What this block does
// - one rate timer, counting 8 or 16 bits, serves async and sync modes
// - after reset the timer is 8-bit; wide divisor select makes it 16-bit
// - timer runs freely; period set by high byte above low byte divisor
// - async rate is clock over 64, 16 or 4 times n+1 per selects
// - sync mode ignores high speed select; rate is clock over 4(n+1)
// - any write to either divisor byte clears the timer immediately
// - baud control bit 2 is not stored and reads zero; other unused control bits read back as written
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sbrg_defines.svh"

module sbrg_rate_gen #(
  parameter int ADDR_W = `SBRG_ADDR_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receiver status in
  input wire logic receive_idle_flag,
  // rate tick toward transmitter and receiver
  output logic rate_tick
);

  // ----------------------------------------
  // helper functions
  // ----------------------------------------

  // prescale limit for the selected formula
  function automatic logic [`SBRG_PRE_W-1:0] pre_limit(input sbrg_pkg::sbrg_cfg_t c);
    logic [`SBRG_PRE_W-1:0] lim;
    lim = `SBRG_PRE_LIM_4;
    if (c.sync_mode) begin
      lim = `SBRG_PRE_LIM_4;
    end else if (c.wide_divisor_select && c.high_speed_select) begin
      lim = `SBRG_PRE_LIM_4;
    end else if (c.wide_divisor_select || c.high_speed_select) begin
      lim = `SBRG_PRE_LIM_16;
    end else begin
      lim = `SBRG_PRE_LIM_64;
    end
    return lim;
  endfunction

  // address match on the byte offset
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  // ----------------------------------------
  // registers and wires
  // ----------------------------------------
  sbrg_pkg::sbrg_apb_state_t state_reg;
  logic [7:0] tx_ctrl_reg;
  logic [7:0] rx_ctrl_reg;
  logic [7:0] baud_ctrl_reg;
  logic [7:0] div_high_reg;
  logic [7:0] div_low_reg;
  logic [`SBRG_PRE_W-1:0] pre_reg;
  logic [15:0] timer_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic rate_tick_reg;
  sbrg_pkg::sbrg_cfg_t cfg;
  logic [`SBRG_PRE_W-1:0] pre_lim;
  logic pre_end;
  logic tick_due;
  logic xfer_done;
  logic wr_en;
  logic div_write;
  logic addr_ok;
  logic [7:0] rd_byte;
  logic [7:0] wr_byte;

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------

  // bundle the rate settings; narrow mode sees only the low byte
  always_comb begin
    cfg.sync_mode = tx_ctrl_reg[`SBRG_TX_SYNC_BIT];
    cfg.high_speed_select = tx_ctrl_reg[`SBRG_TX_HIGH_SPEED_BIT];
    cfg.wide_divisor_select = baud_ctrl_reg[`SBRG_BAUD_WIDE_BIT];
    if (cfg.wide_divisor_select) begin
      cfg.divisor = {div_high_reg, div_low_reg};
    end else begin
      cfg.divisor = {8'h00, div_low_reg};
    end
  end

  // prescale and timer terminal counts
  assign pre_lim = pre_limit(cfg);
  assign pre_end = (pre_reg >= pre_lim);
  assign tick_due = pre_end && (timer_reg >= cfg.divisor);

  // ----------------------------------------
  // apb decode
  // ----------------------------------------

  // a transfer completes at the edge where pready is seen high
  assign xfer_done = psel && penable && pready_reg;
  assign wr_en = xfer_done && pwrite && !pslverr_reg;
  assign div_write = wr_en && (addr_is(paddr, `SBRG_OFF_DIV_HIGH) ||
                               addr_is(paddr, `SBRG_OFF_DIV_LOW));
  assign wr_byte = pwdata[7:0];

  // read mux; unmapped addresses flag an error
  always_comb begin
    rd_byte = 8'h00;
    addr_ok = 1'b1;
    case (paddr)
      `SBRG_OFF_TX_CTRL: rd_byte = tx_ctrl_reg;
      `SBRG_OFF_RX_CTRL: rd_byte = rx_ctrl_reg;
      `SBRG_OFF_BAUD_CTRL: begin
        rd_byte = baud_ctrl_reg & `SBRG_BAUD_WRITE_MASK;
        rd_byte[`SBRG_BAUD_RX_IDLE_BIT] = receive_idle_flag;
      end
      `SBRG_OFF_DIV_HIGH: rd_byte = div_high_reg;
      `SBRG_OFF_DIV_LOW: rd_byte = div_low_reg;
      default: addr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------
  // apb slave phase machine
  // ----------------------------------------

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_reg <= sbrg_pkg::SBRG_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        sbrg_pkg::SBRG_IDLE: begin
          if (psel && penable) begin
            state_reg <= sbrg_pkg::SBRG_ACCESS;
            pready_reg <= 1'b1;
            pslverr_reg <= !addr_ok;
            prdata_reg <= (!pwrite && addr_ok) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
          end
        end
        sbrg_pkg::SBRG_ACCESS: begin
          state_reg <= sbrg_pkg::SBRG_IDLE;
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
          prdata_reg <= 32'h0000_0000;
        end
        default: begin
          state_reg <= sbrg_pkg::SBRG_IDLE;
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------

  // transmit and receive control storage
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tx_ctrl_reg <= `SBRG_RST_TX_CTRL;
      rx_ctrl_reg <= `SBRG_RST_RX_CTRL;
    end else if (wr_en) begin
      if (addr_is(paddr, `SBRG_OFF_TX_CTRL)) begin
        tx_ctrl_reg <= wr_byte;
      end
      if (addr_is(paddr, `SBRG_OFF_RX_CTRL)) begin
        rx_ctrl_reg <= wr_byte;
      end
    end
  end

  // baud control: wide select clear after reset, bit 2 and idle not stored
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      baud_ctrl_reg <= `SBRG_RST_BAUD_CTRL;
    end else if (wr_en && addr_is(paddr, `SBRG_OFF_BAUD_CTRL)) begin
      baud_ctrl_reg <= wr_byte & `SBRG_BAUD_WRITE_MASK;
    end
  end

  // divisor pair
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      div_high_reg <= `SBRG_RST_DIV;
      div_low_reg <= `SBRG_RST_DIV;
    end else if (wr_en) begin
      if (addr_is(paddr, `SBRG_OFF_DIV_HIGH)) begin
        div_high_reg <= wr_byte;
      end
      if (addr_is(paddr, `SBRG_OFF_DIV_LOW)) begin
        div_low_reg <= wr_byte;
      end
    end
  end

  // ----------------------------------------
  // rate timer
  // ----------------------------------------

  // prescaler divides the clock by 64, 16 or 4
  always_ff @(posedge clk_sys) begin
    if (!resetn || div_write) begin
      pre_reg <= '0;
    end else if (pre_end) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  // free running count of prescaled periods, n+1 per tick
  always_ff @(posedge clk_sys) begin
    if (!resetn || div_write) begin
      timer_reg <= 16'h0000;
    end else if (tick_due) begin
      timer_reg <= 16'h0000;
    end else if (pre_end) begin
      timer_reg <= timer_reg + 16'h0001;
    end
  end

  // registered one-cycle tick
  always_ff @(posedge clk_sys) begin
    if (!resetn || div_write) begin
      rate_tick_reg <= 1'b0;
    end else begin
      rate_tick_reg <= tick_due;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign rate_tick = rate_tick_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // completed write to a divisor byte
  sequence s_div_write;
    psel && penable && pready && pwrite && !pslverr &&
      (paddr == `SBRG_OFF_DIV_HIGH || paddr == `SBRG_OFF_DIV_LOW);
  endsequence

  // counters start again from zero
  sequence s_counters_clear;
    (timer_reg == 16'h0000) && (pre_reg == '0) && !rate_tick;
  endsequence

  a_div_write_clears: assert property (s_div_write |=> s_counters_clear)
    else $error("divisor write did not clear the rate timer");

  a_tick_one_cycle: assert property (rate_tick |=> !rate_tick || $past(tick_due))
    else $error("rate tick held longer than its cause");

  a_tick_follows_due: assert property (tick_due && !div_write |=> rate_tick ##1 (timer_reg <= 16'h0001))
    else $error("rate tick missing after terminal count");

  a_sync_divide_four: assert property (cfg.sync_mode |-> pre_lim == `SBRG_PRE_LIM_4)
    else $error("sync mode not dividing by four");

  a_async_divide: assert property (!cfg.sync_mode |-> pre_lim == ((cfg.wide_divisor_select &&
    cfg.high_speed_select) ? `SBRG_PRE_LIM_4 : ((cfg.wide_divisor_select || cfg.high_speed_select) ?
    `SBRG_PRE_LIM_16 : `SBRG_PRE_LIM_64)))
    else $error("async prescale does not match selects");

  a_narrow_divisor: assert property (!cfg.wide_divisor_select |-> cfg.divisor[15:8] == 8'h00)
    else $error("narrow mode sees the high divisor byte");

  a_reset_narrow: assert property ($rose(resetn) |-> !cfg.wide_divisor_select)
    else $error("timer not in 8-bit mode after reset");

  a_reserved_zero: assert property (psel && penable && pready && !pwrite &&
    paddr == `SBRG_OFF_BAUD_CTRL |-> prdata[2] == 1'b0 && prdata[31:8] == 24'h00_0000)
    else $error("unimplemented baud control bit read nonzero");

  a_prescale_step: assert property (!pre_end && !div_write |=> pre_reg == $past(pre_reg) + 1'b1)
    else $error("prescaler did not advance");

endmodule
`default_nettype wire

// >>> common/sbrg_defines.svh
// register offsets, field positions, reset values and prescale limits of the rate generator
`ifndef SBRG_DEFINES_SVH
`define SBRG_DEFINES_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define SBRG_ADDR_W 12
`define SBRG_OFF_TX_CTRL 12'h000
`define SBRG_OFF_RX_CTRL 12'h004
`define SBRG_OFF_BAUD_CTRL 12'h008
`define SBRG_OFF_DIV_HIGH 12'h00c
`define SBRG_OFF_DIV_LOW 12'h010

// ----------------------------------------
// field positions
// ----------------------------------------
`define SBRG_TX_SYNC_BIT 4
`define SBRG_TX_HIGH_SPEED_BIT 2
`define SBRG_BAUD_RX_IDLE_BIT 6
`define SBRG_BAUD_WIDE_BIT 3
`define SBRG_BAUD_WRITE_MASK 8'hbb
`define SBRG_BYTE_MASK 32'h0000_00ff

// ----------------------------------------
// reset values
// ----------------------------------------
`define SBRG_RST_TX_CTRL 8'h00
`define SBRG_RST_RX_CTRL 8'h00
`define SBRG_RST_BAUD_CTRL 8'h00
`define SBRG_RST_DIV 8'h00

// ----------------------------------------
// prescale limits (divide factor minus one)
// ----------------------------------------
`define SBRG_PRE_W 6
`define SBRG_PRE_LIM_64 6'h3f
`define SBRG_PRE_LIM_16 6'h0f
`define SBRG_PRE_LIM_4 6'h03

`endif

// >>> common/sbrg_pkg.sv
// types shared by the serial rate generator
package sbrg_pkg;

  // bus access phase of the register slave
  typedef enum logic [0:0] {
    SBRG_IDLE = 1'b0,
    SBRG_ACCESS = 1'b1
  } sbrg_apb_state_t;

  // rate configuration carried as one bundle
  typedef struct packed {
    logic sync_mode;
    logic wide_divisor_select;
    logic high_speed_select;
    logic [15:0] divisor;
  } sbrg_cfg_t;

endpackage

// >>> tb/sbrg_partner.sv
// partner model: transmitter and receiver side that consumes the rate tick
`timescale 1ns/1ps
`default_nettype none

module sbrg_partner (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // tick in, receiver activity
  input wire logic rate_tick,
  input wire logic rx_active,
  output logic receive_idle_flag,
  // measured tick spacing and tick count
  output var int period,
  output var int ticks
);
  int cnt;

  // idle flag drops while a frame is being received
  always_ff @(posedge clk_sys) begin
    receive_idle_flag <= ~rx_active;
  end

  // one bit time per tick; spacing between ticks is measured
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt <= 0;
      ticks <= 0;
      period <= 0;
    end else if (rate_tick) begin
      period <= cnt + 1;
      cnt <= 0;
      ticks <= ticks + 1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/sbrg_rate_gen_tb.sv
// testbench of the serial rate generator
`timescale 1ns/1ps
`default_nettype none

module serial_baud_rate_generator_tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic receive_idle_flag;
  logic rate_tick;
  logic rx_active = 1'b0;
  int period;
  int ticks;
  int failures = 0;
  int checked = 0;

  always #10 clk_sys = ~clk_sys;

  sbrg_rate_gen i_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .receive_idle_flag(receive_idle_flag), .rate_tick(rate_tick));

  sbrg_partner i_partner (.clk_sys(clk_sys), .resetn(resetn), .rate_tick(rate_tick), .rx_active(rx_active),
    .receive_idle_flag(receive_idle_flag), .period(period), .ticks(ticks));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h got %h", name, exp, got);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready_wait", 32'h2, 32'(k));
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, {24'h000000, d}, rd, er);
  endtask

  task automatic rc(input string name, input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0000_0000, rd, er);
    chk(name, exp, rd);
    chk("pslverr", {31'h0, exp_err}, {31'h0, er});
  endtask

  // wait for k more ticks, bounded; returns cycles waited
  task automatic wt(input int k, output int d);
    int s;
    s = ticks;
    d = 0;
    while (ticks < s + k && d < 5000) begin
      @(posedge clk_sys);
      #1;
      d++;
    end
    if (d >= 5000) chk("tick_wait", 32'h1, 32'h0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rc("tx_ctrl", 12'h000, 32'h0, 1'b0);
    rc("baud_ctrl", 12'h008, 32'h40, 1'b0);
    rc("div_high", 12'h00c, 32'h0, 1'b0);
    rc("unmapped", 12'h014, 32'h0, 1'b1);
    wr(12'h008, 8'hff);
    rc("baud_ctrl", 12'h008, 32'hfb, 1'b0);
    rx_active <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rc("baud_ctrl", 12'h008, 32'hbb, 1'b0);
    rx_active <= 1'b0;
    wr(12'h004, 8'ha5);
    rc("rx_ctrl", 12'h004, 32'ha5, 1'b0);
    wr(12'h008, 8'h00);
    $display("test regs done");
  endtask

  // set mode and divisor, then measure the tick spacing
  task automatic t_rate(input logic [2:0] c, input logic [7:0] hi, input int exp);
    int d;
    wr(12'h000, {3'h0, c[2], 1'b0, c[0], 2'h0});
    wr(12'h008, {4'h0, c[1], 3'h0});
    wr(12'h00c, hi);
    wr(12'h010, 8'h02);
    wt(2, d);
    chk("period", 32'(exp), 32'(period));
  endtask

  task automatic t_modes();
    int m;
    for (int c = 0; c < 8; c++) begin
      m = c[2] ? 4 : (c[1] + c[0] == 0) ? 64 : (c[1] + c[0] == 1) ? 16 : 4;
      t_rate(3'(c), 8'h00, m * 3);
    end
    t_rate(3'b011, 8'h01, 4 * 259);
    t_rate(3'b001, 8'h01, 16 * 3);
    $display("test modes done");
  endtask

  // mid-count divisor write must restart the full period
  task automatic t_restart();
    int d;
    wr(12'h000, 8'h00);
    wr(12'h008, 8'h00);
    wr(12'h00c, 8'h00);
    wr(12'h010, 8'h03);
    wt(1, d);
    repeat (100) @(posedge clk_sys);
    wr(12'h010, 8'h03);
    wt(1, d);
    chk("restart_ok", 32'h1, {31'h0, (d >= 255 && d <= 258)});
    $display("test restart done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_regs();
    t_modes();
    t_restart();
    wrap_up();
  end

  // watchdog against a hung handshake or missing tick
  initial begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
